// ### include/akw_cfg.svh
// constants for the keypad power and watchdog control block
`ifndef AKW_CFG_SVH
`define AKW_CFG_SVH
`define AKW_CMD_POLL 8'h18
`define AKW_ANS_POLL 8'h58
`define AKW_CMD_SWCFG 8'h1C
`define AKW_ANS_SWCFG 8'h5C
`define AKW_CMD_WDOG 8'h1D
`define AKW_ANS_WDOG 8'h5D
`define AKW_KEY_BIT_NORTH 8'h01
`define AKW_KEY_BIT_CONFIRM 8'h02
`define AKW_KEY_BIT_ABORT 8'h04
`define AKW_KEY_BIT_WEST 8'h08
`define AKW_KEY_BIT_EAST 8'h10
`define AKW_KEY_BIT_SOUTH 8'h20
`define AKW_CFG_AUTO_POL 0
`define AKW_CFG_RESET_INV 1
`define AKW_CFG_POWER_INV 2
`define AKW_CFG_BLANK 4
`define AKW_CFG_KEY_RESET 5
`define AKW_CFG_KEY_PWR_ON 6
`define AKW_CFG_KEY_PWR_OFF 7
`define AKW_CFG_RESET_VAL 8'h00
`define AKW_PULSE_HOLD 8'hFF
`define AKW_PULSE_DEFAULT 8'h20
`define AKW_SENSE_DEFAULT 1'b1
`define AKW_CLK_HZ 100000000
`define AKW_TICK_PER_S 32
`define AKW_TICK_CYCLES (`AKW_CLK_HZ / `AKW_TICK_PER_S)
`define AKW_LONG_HOLD_S 4
`define AKW_LONG_HOLD_TICKS (`AKW_LONG_HOLD_S * `AKW_TICK_PER_S)
`define AKW_SHORT_PRESS_MS 250
`define AKW_SHORT_PRESS_TICKS ((`AKW_SHORT_PRESS_MS * `AKW_TICK_PER_S + 999) / 1000)
`define AKW_RESET_PULSE_S 1
`define AKW_RESET_PULSE_TICKS (`AKW_RESET_PULSE_S * `AKW_TICK_PER_S)
`define AKW_EXTEND_S 5
`define AKW_EXTEND_TICKS (`AKW_EXTEND_S * `AKW_TICK_PER_S)
`endif

// ### include/akw_pkg.sv
// types shared by the keypad power and watchdog control block
package akw_pkg;
	typedef enum logic [2:0] {
		AKW_IDLE = 3'b000,
		AKW_RESET_PULSE = 3'b001,
		AKW_POWER_PULSE = 3'b010,
		AKW_POWER_EXTEND = 3'b011,
		AKW_RESTART = 3'b100
	} akw_state_t;
	typedef enum logic [1:0] {
		AKW_LINE_RESET = 2'b00,
		AKW_LINE_POWER = 2'b01
	} akw_line_t;
endpackage

// ### include/akw_tick_if.sv
// tick strobe shared between the control block and its tick divider
interface akw_tick_if;
	logic tick;
	modport source (output tick);
	modport sink (input tick);
endinterface

// ### verilog/akw_tick_gen.sv
// divider making the 1/32 second tick strobe
`include "akw_cfg.svh"
module akw_tick_gen #(
	parameter int TICK_CYCLES = `AKW_TICK_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	akw_tick_if.source tick_if
);
	logic [21:0] count;
	logic tick_q;
	wire logic wrap = (count == 22'(TICK_CYCLES - 1));

	// free-running divider, one-cycle strobe at each wrap
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count <= 22'h000000;
			tick_q <= 1'b0;
		end else begin
			count <= wrap ? 22'h000000 : count + 22'h000001;
			tick_q <= wrap;
		end
	end
	assign tick_if.tick = tick_q;
endmodule

// ### verilog/akw_control.sv
// keypad poll, host power and reset pulses, and host watchdog
`include "akw_cfg.svh"
module akw_control #(
	parameter int TICK_CYCLES = `AKW_TICK_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [1:0] cmd_len_in,
	input wire logic [7:0] cmd_data0_in,
	input wire logic [7:0] cmd_data1_in,
	input wire logic [7:0] cmd_data2_in,
	input wire logic [5:0] keys_in,
	input wire logic sense_pin_in,
	input wire logic sense_supply_in,
	input wire logic reset_line_in,
	input wire logic power_line_in,
	output logic ans_valid_out,
	output logic [7:0] ans_code_out,
	output logic [1:0] ans_len_out,
	output logic [7:0] ans_data0_out,
	output logic [7:0] ans_data1_out,
	output logic [7:0] ans_data2_out,
	output logic reset_line_out,
	output logic reset_line_oe_out,
	output logic power_line_out,
	output logic power_line_oe_out,
	output logic blank_screen_out,
	output logic msg_reset_out,
	output logic msg_power_on_out,
	output logic msg_power_off_out,
	output logic self_restart_out,
	output logic busy_out,
	output logic [7:0] saved_cfg_out,
	output logic [7:0] saved_pulse_out,
	output logic saved_sense_out
);
	akw_tick_if tick_bus ();
	akw_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.tick_if(tick_bus.source)
	);
	wire logic tick = tick_bus.tick;

	// one key in the mask set; the same decode is used for several gestures
	function automatic logic key_held(input logic [5:0] keys, input logic [7:0] bit_mask);
		key_held = |(keys & bit_mask[5:0]);
	endfunction

	akw_pkg::akw_state_t state;
	akw_pkg::akw_state_t next_state;
	logic [7:0] cfg;
	logic [7:0] pulse_len;
	logic sense_sel;
	logic [5:0] keys_prev;
	logic [5:0] pressed_hist;
	logic [5:0] released_hist;
	logic [7:0] hold_ticks;
	logic [7:0] pulse_ticks;
	logic [7:0] wd_timeout;
	logic [5:0] wd_sub;
	logic [7:0] wd_secs;
	logic wd_armed;
	logic sense_prev;
	logic reset_idle;
	logic power_idle;

	// host power sense source picked by the third config byte
	wire logic sense = sense_sel ? sense_supply_in : sense_pin_in;
	wire logic sense_rise = sense & ~sense_prev;
	wire logic confirm = key_held(keys_in, `AKW_KEY_BIT_CONFIRM);
	wire logic abort = key_held(keys_in, `AKW_KEY_BIT_ABORT);
	wire logic idle = (state == akw_pkg::AKW_IDLE);
	wire logic accept = cmd_valid_in & (state != akw_pkg::AKW_RESTART);
	wire logic is_poll = accept & (cmd_code_in == `AKW_CMD_POLL) & (cmd_len_in == 2'b00);
	wire logic is_swcfg = accept & (cmd_code_in == `AKW_CMD_SWCFG) & (cmd_len_in != 2'b00);
	wire logic is_wdog = accept & (cmd_code_in == `AKW_CMD_WDOG) & (cmd_len_in == 2'b01);
	wire logic [5:0] new_press = keys_in & ~keys_prev;
	wire logic [5:0] new_release = ~keys_in & keys_prev;

	// key gesture triggers measured in whole ticks of hold time, then watchdog expiry in seconds and the pulse ends
	wire logic held_long = (hold_ticks == 8'(`AKW_LONG_HOLD_TICKS));
	wire logic held_short = (hold_ticks == 8'(`AKW_SHORT_PRESS_TICKS));
	wire logic go_reset_key = idle & cfg[`AKW_CFG_KEY_RESET] & sense & confirm & held_long;
	wire logic go_power_on = idle & cfg[`AKW_CFG_KEY_PWR_ON] & ~sense & confirm & held_short;
	wire logic go_power_off = idle & cfg[`AKW_CFG_KEY_PWR_OFF] & sense & abort & held_long;
	wire logic wd_expire = wd_armed & (wd_secs == wd_timeout) & (wd_timeout != 8'h00);
	wire logic go_reset_wd = idle & wd_expire;
	wire logic pulse_done_reset = tick & (pulse_ticks == 8'(`AKW_RESET_PULSE_TICKS - 1));
	wire logic hold_mode = (pulse_len == `AKW_PULSE_HOLD);
	wire logic pulse_done_power = hold_mode ? (sense != sense_prev)
		: (tick & (pulse_ticks == pulse_len - 8'h01));
	wire logic extend_done = ~abort | (tick & (pulse_ticks == 8'(`AKW_EXTEND_TICKS - 1)));

	// active levels: sampled opposite of idle, else invert bits, else low
	wire logic reset_act = cfg[`AKW_CFG_AUTO_POL] ? ~reset_idle : cfg[`AKW_CFG_RESET_INV];
	wire logic power_act = cfg[`AKW_CFG_AUTO_POL] ? ~power_idle : cfg[`AKW_CFG_POWER_INV];

	// sequencer for the pulses and the self restart after a reset or power-on pulse
	always_comb begin
		next_state = state;
		case (state)
			akw_pkg::AKW_IDLE: begin
				if (go_reset_key | go_reset_wd) begin
					next_state = akw_pkg::AKW_RESET_PULSE;
				end else if (go_power_on | go_power_off) begin
					next_state = akw_pkg::AKW_POWER_PULSE;
				end
			end
			akw_pkg::AKW_RESET_PULSE: begin
				if (pulse_done_reset) begin
					next_state = akw_pkg::AKW_RESTART;
				end
			end
			akw_pkg::AKW_POWER_PULSE: begin
				if (pulse_done_power) begin
					if (msg_power_on_out) begin
						next_state = akw_pkg::AKW_RESTART;
					end else if (abort) begin
						next_state = akw_pkg::AKW_POWER_EXTEND;
					end else begin
						next_state = akw_pkg::AKW_IDLE;
					end
				end
			end
			akw_pkg::AKW_POWER_EXTEND: begin
				if (extend_done) begin
					next_state = akw_pkg::AKW_IDLE;
				end
			end
			akw_pkg::AKW_RESTART: begin
				next_state = akw_pkg::AKW_IDLE;
			end
			default: begin
				next_state = akw_pkg::AKW_IDLE;
			end
		endcase
	end

	// state and pulse tick counter
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= akw_pkg::AKW_IDLE;
			pulse_ticks <= 8'h00;
		end else begin
			state <= next_state;
			if (next_state != state) begin
				pulse_ticks <= 8'h00;
			end else if (tick) begin
				pulse_ticks <= pulse_ticks + 8'h01;
			end
		end
	end

	// hold timer: ticks the relevant key has been held, saturating
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hold_ticks <= 8'h00;
		end else if (~(confirm | abort) | ~idle) begin
			hold_ticks <= 8'h00;
		end else if (tick & (hold_ticks != 8'hFF)) begin
			hold_ticks <= hold_ticks + 8'h01;
		end
	end

	// switch configuration; power-up values match the boot defaults
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg <= `AKW_CFG_RESET_VAL;
			pulse_len <= `AKW_PULSE_DEFAULT;
			sense_sel <= `AKW_SENSE_DEFAULT;
		end else if (is_swcfg) begin
			cfg <= cmd_data0_in;
			pulse_len <= (cmd_len_in >= 2'b10) ? cmd_data1_in : `AKW_PULSE_DEFAULT;
			if (cmd_len_in == 2'b11) begin
				sense_sel <= cmd_data2_in[0];
			end
		end
	end

	// keypad history: new events win over the clear made by a poll
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			keys_prev <= 6'h00;
			pressed_hist <= 6'h00;
			released_hist <= 6'h00;
		end else begin
			keys_prev <= keys_in;
			pressed_hist <= (is_poll ? 6'h00 : pressed_hist) | new_press;
			released_hist <= (is_poll ? 6'h00 : released_hist) | new_release;
		end
	end

	// idle level of each line sampled only while released
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reset_idle <= 1'b1;
			power_idle <= 1'b1;
			sense_prev <= 1'b0;
		end else begin
			sense_prev <= sense;
			if (~reset_line_oe_out) begin
				reset_idle <= reset_line_in;
			end
			if (~power_line_oe_out) begin
				power_idle <= power_line_in;
			end
		end
	end

	// watchdog: disabled at power-up, counts seconds, disarms after firing
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wd_armed <= 1'b0;
			wd_timeout <= 8'h00;
			wd_sub <= 6'h00;
			wd_secs <= 8'h00;
		end else if (is_wdog) begin
			wd_armed <= (cmd_data0_in != 8'h00);
			wd_timeout <= cmd_data0_in;
			wd_sub <= 6'h00;
			wd_secs <= 8'h00;
		end else if (go_reset_wd) begin
			wd_armed <= 1'b0;
		end else if (wd_armed & tick & ~wd_expire) begin
			if (wd_sub == 6'(`AKW_TICK_PER_S - 1)) begin
				wd_sub <= 6'h00;
				wd_secs <= wd_secs + 8'h01;
			end else begin
				wd_sub <= wd_sub + 6'h01;
			end
		end
	end

	// answers; polled masks cover every key regardless of reporting enables
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ans_valid_out <= 1'b0;
			ans_code_out <= 8'h00;
			ans_len_out <= 2'b00;
			ans_data0_out <= 8'h00;
			ans_data1_out <= 8'h00;
			ans_data2_out <= 8'h00;
		end else begin
			ans_valid_out <= is_poll | is_swcfg | is_wdog;
			if (is_poll) begin
				ans_code_out <= `AKW_ANS_POLL;
				ans_len_out <= 2'b11;
				ans_data0_out <= {2'b00, keys_in};
				ans_data1_out <= {2'b00, pressed_hist | new_press};
				ans_data2_out <= {2'b00, released_hist | new_release};
			end else if (is_swcfg | is_wdog) begin
				ans_code_out <= is_swcfg ? `AKW_ANS_SWCFG : `AKW_ANS_WDOG;
				ans_len_out <= 2'b00;
				ans_data0_out <= 8'h00;
				ans_data1_out <= 8'h00;
				ans_data2_out <= 8'h00;
			end
		end
	end

	// line drivers: high impedance except during a pulse or the power extension
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reset_line_oe_out <= 1'b0;
			reset_line_out <= 1'b0;
			power_line_oe_out <= 1'b0;
			power_line_out <= 1'b0;
		end else begin
			reset_line_oe_out <= (next_state == akw_pkg::AKW_RESET_PULSE);
			reset_line_out <= reset_act;
			power_line_oe_out <= (next_state == akw_pkg::AKW_POWER_PULSE)
				| (next_state == akw_pkg::AKW_POWER_EXTEND);
			power_line_out <= power_act;
		end
	end

	// messages, screen blanking, restart strobe and saved settings
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			msg_reset_out <= 1'b0;
			msg_power_on_out <= 1'b0;
			msg_power_off_out <= 1'b0;
			blank_screen_out <= 1'b0;
			self_restart_out <= 1'b0;
			busy_out <= 1'b0;
			saved_cfg_out <= `AKW_CFG_RESET_VAL;
			saved_pulse_out <= `AKW_PULSE_DEFAULT;
			saved_sense_out <= `AKW_SENSE_DEFAULT;
		end else begin
			msg_reset_out <= (next_state == akw_pkg::AKW_RESET_PULSE);
			if (idle) begin
				msg_power_on_out <= go_power_on;
				msg_power_off_out <= go_power_off;
			end else if (next_state == akw_pkg::AKW_IDLE) begin
				msg_power_on_out <= 1'b0;
				msg_power_off_out <= 1'b0;
			end
			blank_screen_out <= cfg[`AKW_CFG_BLANK] & ~sense;
			self_restart_out <= (state == akw_pkg::AKW_RESTART) | (idle & sense_rise);
			busy_out <= (next_state == akw_pkg::AKW_RESTART);
			saved_cfg_out <= cfg;
			saved_pulse_out <= pulse_len;
			saved_sense_out <= sense_sel;
		end
	end
endmodule

// ### testbench/akw_control_props.sv
// assertion checker for the keypad power and watchdog control block
module akw_control_props #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [1:0] cmd_len_in,
	input wire logic sense_pin_in,
	input wire logic sense_supply_in,
	input wire logic ans_valid_out,
	input wire logic [7:0] ans_code_out,
	input wire logic [1:0] ans_len_out,
	input wire logic [7:0] ans_data0_out,
	input wire logic reset_line_out,
	input wire logic reset_line_oe_out,
	input wire logic power_line_out,
	input wire logic power_line_oe_out,
	input wire logic blank_screen_out,
	input wire logic self_restart_out,
	input wire logic busy_out,
	input wire logic [7:0] saved_cfg_out,
	input wire logic saved_sense_out
);
	// reset pulse width; far too long for a repetition, so counted
	logic [31:0] hi_len;
	wire host_sense = saved_sense_out ? sense_supply_in : sense_pin_in;
	always_ff @(posedge clk_in) begin
		if (rst_in || !reset_line_oe_out) hi_len <= 32'h00000000;
		else hi_len <= hi_len + 32'h00000001;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// a command the block may take this cycle
	sequence s_take(logic [7:0] c);
		cmd_valid_in && !busy_out && cmd_code_in == c;
	endsequence
	a_poll_answer: assert property (s_take(8'h18) ##0 cmd_len_in == 2'h0 |=>
		ans_valid_out && ans_code_out == 8'h58 && ans_len_out == 2'h3) else $error("bad poll answer");
	a_poll_spare_bits: assert property (ans_valid_out && ans_code_out == 8'h58 |->
		ans_data0_out[7:6] == 2'h0) else $error("poll mask spare bits set");
	a_cfg_ack: assert property (s_take(8'h1C) ##0 cmd_len_in != 2'h0 |=>
		ans_valid_out && ans_code_out == 8'h5C && ans_len_out == 2'h0) else $error("bad cfg ack");
	a_wdog_ack: assert property (s_take(8'h1D) ##0 cmd_len_in == 2'h1 |=>
		ans_valid_out && ans_code_out == 8'h5D && ans_len_out == 2'h0) else $error("bad wdog ack");
	a_busy_refuse: assert property (busy_out && cmd_valid_in |=> !ans_valid_out)
		else $error("answer while busy");
	a_answer_cause: assert property (ans_valid_out |-> $past(cmd_valid_in))
		else $error("answer without command");
	a_reset_width: assert property ($fell(reset_line_oe_out) |-> hi_len >= 31 * TICK_CYCLES
		&& hi_len <= 33 * TICK_CYCLES) else $error("reset pulse width wrong");
	a_fixed_polarity: assert property (!saved_cfg_out[0] |->
		(!reset_line_oe_out || reset_line_out == saved_cfg_out[1]) &&
		(!power_line_oe_out || power_line_out == saved_cfg_out[2])) else $error("bad polarity");
	a_blank_follow: assert property ((saved_cfg_out[4] && !host_sense) [*4] |->
		blank_screen_out) else $error("screen not blanked");
	a_restart_pulse: assert property (self_restart_out |=> !self_restart_out)
		else $error("restart not a pulse");
endmodule
bind akw_control akw_control_props #(.TICK_CYCLES(TICK_CYCLES)) akw_control_props_i (.clk_in,
	.rst_in, .cmd_valid_in, .cmd_code_in, .cmd_len_in, .sense_pin_in, .sense_supply_in,
	.ans_valid_out, .ans_code_out, .ans_len_out, .ans_data0_out, .reset_line_out,
	.reset_line_oe_out, .power_line_out, .power_line_oe_out, .blank_screen_out,
	.self_restart_out, .busy_out, .saved_cfg_out, .saved_sense_out);

// ### testbench/akw_host_model.sv
// host machine model: pulled-up control inputs and a reset tally
module akw_host_model (
	input wire logic rst_drive_in,
	input wire logic rst_oe_in,
	input wire logic pwr_drive_in,
	input wire logic pwr_oe_in,
	output logic rst_level_out,
	output logic pwr_level_out,
	output logic [7:0] pulses_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// released lines float up to the host's pull-up level
	assign rst_level_out = rst_oe_in ? rst_drive_in : 1'b1;
	assign pwr_level_out = pwr_oe_in ? pwr_drive_in : 1'b1;
	// host resets seen, for the one-shot watchdog check and the keypad reset check
	initial pulses_out = 8'h00;
	always @(posedge rst_oe_in) pulses_out <= pulses_out + 8'h01;
endmodule

// ### testbench/akw_control_test.sv
// self-checking bench for the keypad power and watchdog control block
module akw_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 4;
	logic clk_in, rst_in, cmd_valid_in, sense_pin_in, sense_supply_in, reset_line_in;
	logic power_line_in, ans_valid_out, reset_line_out, reset_line_oe_out, power_line_out;
	logic power_line_oe_out, blank_screen_out, msg_reset_out, msg_power_on_out;
	logic msg_power_off_out, self_restart_out, busy_out, saved_sense_out;
	logic [1:0] cmd_len_in, ans_len_out;
	logic [5:0] keys_in;
	logic [7:0] cmd_code_in, cmd_data0_in, cmd_data1_in, cmd_data2_in, ans_code_out, pulses;
	logic [7:0] ans_data0_out, ans_data1_out, ans_data2_out, saved_cfg_out, saved_pulse_out;
	int mismatches, checked, n;
	// short tick so the gestures take hundreds of cycles, not millions
	akw_control #(.TICK_CYCLES(TC)) akw_control_i (.clk_in, .rst_in, .cmd_valid_in, .cmd_code_in,
		.cmd_len_in, .cmd_data0_in, .cmd_data1_in, .cmd_data2_in, .keys_in, .sense_pin_in,
		.sense_supply_in, .reset_line_in, .power_line_in, .ans_valid_out, .ans_code_out,
		.ans_len_out, .ans_data0_out, .ans_data1_out, .ans_data2_out, .reset_line_out,
		.reset_line_oe_out, .power_line_out, .power_line_oe_out, .blank_screen_out,
		.msg_reset_out, .msg_power_on_out, .msg_power_off_out, .self_restart_out, .busy_out,
		.saved_cfg_out, .saved_pulse_out, .saved_sense_out);
	akw_host_model akw_host_model_i (.rst_drive_in(reset_line_out), .rst_oe_in(reset_line_oe_out),
		.pwr_drive_in(power_line_out), .pwr_oe_in(power_line_oe_out),
		.rst_level_out(reset_line_in), .pwr_level_out(power_line_in), .pulses_out(pulses));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("counts: %0d compared, %0d mismatched", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one command cycle; ec is the expected answer code, zero when refused
	task automatic send(input logic [7:0] c, input logic [1:0] l, input logic [7:0] x0,
		input logic [7:0] x1, input logic [7:0] ec);
		@(posedge clk_in);
		cmd_valid_in <= 1'b1;
		cmd_code_in <= c;
		cmd_len_in <= l;
		cmd_data0_in <= x0;
		cmd_data1_in <= x1;
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		#1;
		chk({15'h0000, ans_valid_out}, {15'h0000, ec != 8'h00});
		if (ec != 8'h00) chk({ans_code_out, 6'h00, ans_len_out}, {ec, 6'h00, ec == 8'h58, ec == 8'h58});
	endtask
	task automatic poll(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
		send(8'h18, 2'h0, 8'h00, 8'h00, 8'h58);
		chk({ans_data0_out, ans_data1_out}, {e0, e1});
		chk({8'h00, ans_data2_out}, {8'h00, e2});
	endtask
	function automatic logic sel(input int s);
		return s == 0 ? reset_line_oe_out : (s == 1 ? power_line_oe_out : self_restart_out);
	endfunction
	// bounded wait: 0 reset enable, 1 power enable, 2 restart strobe
	task automatic wait_on(input int s, input logic v, input int lim);
		for (n = 0; sel(s) !== v; n++) begin
			if (n == lim) begin
				mismatches++;
				$display("MISMATCH %0t wait %0d ran out", $time, s);
				close_out();
			end
			@(posedge clk_in);
			#1;
		end
	endtask
	task automatic setk(input logic [5:0] k);
		@(posedge clk_in);
		keys_in <= k;
	endtask
	initial begin
		{rst_in, sense_pin_in, sense_supply_in} = 3'h7;
		{cmd_valid_in, cmd_len_in, keys_in} = 9'h000;
		{cmd_code_in, cmd_data0_in, cmd_data1_in, cmd_data2_in} = 32'h00000000;
		mismatches = 0;
		checked = 0;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		chk({saved_cfg_out, saved_pulse_out}, 16'h0020);
		chk({14'h0000, saved_sense_out, reset_line_oe_out | power_line_oe_out}, 16'h0002);
		poll(8'h00, 8'h00, 8'h00);
		setk(6'h11);
		poll(8'h11, 8'h11, 8'h00);
		setk(6'h2E);
		poll(8'h2E, 8'h2E, 8'h11);
		setk(6'h00);
		poll(8'h00, 8'h00, 8'h2E);
		send(8'h30, 2'h0, 8'h00, 8'h00, 8'h00);
		send(8'h18, 2'h1, 8'h00, 8'h00, 8'h00);
		$display("test poll done");
		// power-on by confirm, sensing on the pin while the supply sense stays high
		send(8'h1C, 2'h3, 8'h50, 8'h04, 8'h5C);
		// saved copies trail the live settings by one register stage
		@(posedge clk_in);
		#1;
		chk({saved_cfg_out, saved_pulse_out}, 16'h5004);
		chk({15'h0000, saved_sense_out}, 16'h0000);
		@(posedge clk_in);
		sense_pin_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		#1;
		chk({15'h0000, blank_screen_out}, 16'h0001);
		setk(6'h02);
		wait_on(1, 1'b1, 12 * TC);
		chk({14'h0000, power_line_in, msg_power_on_out}, 16'h0001);
		chk({15'h0000, n >= 7 * TC}, 16'h0001);
		setk(6'h00);
		wait_on(1, 1'b0, 8 * TC);
		chk({15'h0000, n >= 2 * TC}, 16'h0001);
		wait_on(2, 1'b1, 8);
		@(posedge clk_in);
		sense_pin_in <= 1'b1;
		wait_on(2, 1'b1, 8);
		repeat (4) @(posedge clk_in);
		#1;
		chk({15'h0000, blank_screen_out}, 16'h0000);
		$display("test power on done");
		// power-off by abort, held past the pulse, power line inverted
		send(8'h1C, 2'h2, 8'h84, 8'h02, 8'h5C);
		setk(6'h04);
		wait_on(1, 1'b1, 132 * TC);
		chk({15'h0000, n >= 126 * TC}, 16'h0001);
		chk({13'h0000, power_line_in, msg_power_off_out, msg_power_on_out}, 16'h0006);
		wait_on(1, 1'b0, 170 * TC);
		chk({15'h0000, n >= 150 * TC}, 16'h0001);
		setk(6'h00);
		$display("test power off done");
		// watchdog: arm and disable, then arm, feed once and let it expire
		send(8'h1C, 2'h1, 8'h01, 8'h00, 8'h5C);
		send(8'h1D, 2'h1, 8'h01, 8'h00, 8'h5D);
		send(8'h1D, 2'h1, 8'h00, 8'h00, 8'h5D);
		repeat (200) @(posedge clk_in);
		chk({8'h00, pulses}, 16'h0000);
		send(8'h1D, 2'h1, 8'h01, 8'h00, 8'h5D);
		repeat (60) @(posedge clk_in);
		send(8'h1D, 2'h1, 8'h01, 8'h00, 8'h5D);
		wait_on(0, 1'b1, 40 * TC);
		chk({15'h0000, n >= 30 * TC}, 16'h0001);
		chk({15'h0000, reset_line_in}, 16'h0000);
		wait_on(0, 1'b0, 40 * TC);
		repeat (300) @(posedge clk_in);
		chk({8'h00, pulses}, 16'h0001);
		$display("test watchdog done");
		// keypad reset, with polls streaming as the pulse ends
		send(8'h1C, 2'h1, 8'h20, 8'h00, 8'h5C);
		setk(6'h02);
		wait_on(0, 1'b1, 132 * TC);
		chk({15'h0000, msg_reset_out}, 16'h0001);
		// polls stream through the pulse end so the restart cycle sees one
		@(posedge clk_in);
		cmd_code_in <= 8'h18;
		cmd_len_in <= 2'h0;
		cmd_valid_in <= 1'b1;
		wait_on(0, 1'b0, 40 * TC);
		wait_on(2, 1'b1, 8);
		chk({15'h0000, ans_valid_out}, 16'h0000);
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		keys_in <= 6'h00;
		chk({8'h00, pulses}, 16'h0002);
		$display("test keypad reset done");
		close_out();
	end
endmodule
